//--- pdc_pkg.sv
// package for the power-down mode controller: register map, fields, types
// assumes a 32-bit avalon-mm slave with byte addresses
package pdc_pkg;
  // register byte offsets
  localparam logic [3:0] OFS_CTRL   = 4'h0;  // second system control register
  localparam logic [3:0] OFS_STATUS = 4'h4;  // reset flags / current mode
  localparam logic [3:0] OFS_BUS    = 4'h8;  // address windows, bus mode
  localparam logic [3:0] OFS_CMD    = 4'hC;  // instruction word input
  // field positions in the control register
  localparam int POWER_DOWN_PIN_COUNTER_CONTROL_LSB = 4;
  localparam logic [1:0] POWER_DOWN_PIN_COUNTER_CONTROL_RESET = 2'h0;
  // status fields
  localparam int FLAG_PON = 0;
  localparam int FLAG_PDR = 1;
  localparam int FLAG_MODE_LSB = 4;
  // protected power-down opcode, two halves must mirror each other
  localparam logic [15:0] PD_OP_HI = 16'h97A0;
  localparam logic [15:0] PD_OP_LO = 16'h685F;
  localparam logic [1:0] SLP_IDLE = 2'h0;
  // bus field positions
  localparam int BUS_WIN_LSB = 0;
  localparam int BUS_MUX8 = 8;
  localparam int BUS_DEMUX = 9;
  localparam int PORT_W = 16;

  typedef enum logic [1:0] {
    PDC_RUN,
    PDC_IDLE,
    PDC_SLEEP,
    PDC_PDOWN
  } pdc_mode_t;

  // pin values coming from ports and peripherals in run mode
  typedef struct packed {
    logic [15:0] p0_val;
    logic [15:0] p0_oe;
    logic [15:0] p1_val;
    logic [15:0] p1_oe;
    logic        ale;
    logic        rd_n;
    logic        wr_n;
    logic        system_clock_output;
    logic        programmable_frequency_output;
  } pdc_pins_t;

  // last external bus address
  typedef struct packed {
    logic [15:0] lo;
    logic [2:0]  hi;
  } pdc_addr_t;
endpackage

//--- pdc_hold.sv
// freeze register for pin values during sleep and power-down
// assumes a single clock and synchronous active high reset
`timescale 1ns/100ps
module pdc_hold
  import pdc_pkg::*;
(
  input  wire logic             clk_i,
  input  wire logic             srst_i,
  input  wire logic             freeze_i,
  input  wire pdc_pkg::pdc_pins_t d_i,
  output pdc_pkg::pdc_pins_t    q_o
);
  // follows live values until frozen, then keeps the last state
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      q_o <= '0;
    else if (!freeze_i)
      q_o <= d_i;
  end
endmodule

//--- pdc_top.sv
// power-down mode controller: entry, exit and pin states in low power
// assumes avalon-mm master on clk_i, pins from outside the clock domain
`timescale 1ns/100ps
module pdc_top
  import pdc_pkg::*;
(
  input  wire logic               clk_i,
  input  wire logic               srst_i,
  input  wire logic               por_i,
  input  wire logic               hw_reset_n_i,
  input  wire logic               nmi_n_i,
  input  wire logic [3:0]         avs_address_i,
  input  wire logic               avs_read_i,
  input  wire logic               avs_write_i,
  input  wire logic [31:0]        avs_writedata_i,
  input  wire logic [3:0]         avs_byteenable_i,
  output logic [31:0]             avs_readdata_o,
  output logic                    avs_waitrequest_o,
  input  wire logic               instr_done_i,
  input  wire logic               idle_req_i,
  input  wire pdc_pkg::pdc_pins_t live_pins_i,
  input  wire pdc_pkg::pdc_addr_t last_addr_i,
  input  wire logic [15:0]        p0_latch_i,
  input  wire logic [15:0]        p1_latch_i,
  output pdc_pkg::pdc_pins_t      pins_o,
  output logic                    core_clk_en_o,
  output logic                    wdt_run_o,
  output logic                    tod_clk_en_o,
  output logic                    tod_osc_en_o,
  output logic                    ram_retain_o,
  output logic                    sys_reset_o,
  output logic                    bus_pins_en_o,
  output logic [1:0]              mode_o
);
  import pdc_pkg::*;

  pdc_mode_t   mode;
  pdc_mode_t   next_mode;
  logic [1:0]  sync_rst_n;
  logic [1:0]  sync_nmi_n;
  logic        rst_n_s;
  logic        nmi_n_s;
  logic [1:0]  power_down_pin_counter_control;
  logic [1:0]  sleep_cfg;
  logic [7:0]  address_window_active_bit;
  logic        mux8;
  logic        demux;
  logic [15:0] port_dir_out;
  logic        flag_pon;
  logic        flag_pdr;
  logic        pd_armed;
  logic [15:0] cmd_hi;
  logic        cmd_hi_ok;
  logic        ext_rst;
  logic        bus_rd;
  logic        bus_wr;
  logic        rd_wait_done;
  pdc_pins_t   held;
  pdc_pins_t   next_pins;
  logic        stopped;

  // match of one half of the protected encoding
  function automatic logic half_ok(input logic [15:0] w,
                                   input logic [15:0] ref_w);
    half_ok = (w == ref_w);
  endfunction

  // pins come from outside the clock domain: two flops first
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      sync_rst_n <= 2'h3;
      sync_nmi_n <= 2'h3;
    end
    else
    begin
      sync_rst_n <= {sync_rst_n[0], hw_reset_n_i};
      sync_nmi_n <= {sync_nmi_n[0], nmi_n_i};
    end
  end
  assign rst_n_s = sync_rst_n[1];
  assign nmi_n_s = sync_nmi_n[1];
  // register and port defaults come back on an external reset
  assign ext_rst = srst_i || !rst_n_s;

  // reads take one wait state so the registered data stand at the
  // edge where waitrequest is low; writes complete at once
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      rd_wait_done <= 1'b0;
    else
      rd_wait_done <= avs_read_i && !rd_wait_done;
  end
  assign avs_waitrequest_o = avs_read_i && !rd_wait_done;
  assign bus_rd = avs_read_i && !rd_wait_done;
  assign bus_wr = avs_write_i && (mode == PDC_RUN);

  // control and bus registers, reset to defaults
  always_ff @(posedge clk_i)
  begin
    if (ext_rst)
    begin
      power_down_pin_counter_control <= POWER_DOWN_PIN_COUNTER_CONTROL_RESET;
      sleep_cfg <= SLP_IDLE;
      address_window_active_bit <= 8'h00;
      mux8 <= 1'b0;
      demux <= 1'b0;
      port_dir_out <= 16'h0000;
    end
    else if (bus_wr && avs_address_i == OFS_CTRL && avs_byteenable_i[0])
    begin
      power_down_pin_counter_control <=
        avs_writedata_i[POWER_DOWN_PIN_COUNTER_CONTROL_LSB +: 2];
      sleep_cfg <= avs_writedata_i[1:0];
    end
    else if (bus_wr && avs_address_i == OFS_BUS)
    begin
      if (avs_byteenable_i[0])
        address_window_active_bit <= avs_writedata_i[BUS_WIN_LSB +: 8];
      if (avs_byteenable_i[1])
      begin
        mux8 <= avs_writedata_i[BUS_MUX8];
        demux <= avs_writedata_i[BUS_DEMUX];
      end
      if (avs_byteenable_i[2])
        port_dir_out[7:0] <= avs_writedata_i[23:16];
      if (avs_byteenable_i[3])
        port_dir_out[15:8] <= avs_writedata_i[31:24];
    end
  end

  // reset identification: por sets power-on, reset out of pd sets restart
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      flag_pon <= 1'b0;
      flag_pdr <= 1'b0;
    end
    else if (por_i)
    begin
      flag_pon <= 1'b1;
      flag_pdr <= 1'b0;
    end
    else if (mode == PDC_PDOWN && !rst_n_s)
    begin
      flag_pdr <= 1'b1;
      flag_pon <= 1'b0;
    end
    else if (bus_wr && avs_address_i == OFS_STATUS && avs_byteenable_i[0])
    begin
      // write one clears; reset events above take priority
      flag_pon <= flag_pon & ~avs_writedata_i[FLAG_PON];
      flag_pdr <= flag_pdr & ~avs_writedata_i[FLAG_PDR];
    end
  end

  // protected instruction: high half then complementary low half
  always_ff @(posedge clk_i)
  begin
    if (ext_rst)
    begin
      cmd_hi <= 16'h0000;
      cmd_hi_ok <= 1'b0;
      pd_armed <= 1'b0;
    end
    else
    begin
      if (bus_wr && avs_address_i == OFS_CMD && (&avs_byteenable_i))
      begin
        cmd_hi <= avs_writedata_i[31:16];
        cmd_hi_ok <= half_ok(avs_writedata_i[31:16], PD_OP_HI) &&
                     half_ok(avs_writedata_i[15:0], PD_OP_LO) &&
                     half_ok(avs_writedata_i[31:16],
                             ~avs_writedata_i[15:0]);
      end
      // armed only if nmi low when the checked command is taken; stays armed until instr_done_i
      if (cmd_hi_ok && !pd_armed)
      begin
        pd_armed <= !nmi_n_s;
        cmd_hi_ok <= 1'b0;
      end
      else if (pd_armed && instr_done_i)
        pd_armed <= 1'b0;
    end
  end

  // mode sequencing
  always_comb
  begin
    next_mode = mode;
    case (mode)
      PDC_RUN:
        if (pd_armed && instr_done_i)
          next_mode = PDC_PDOWN;
        else if (idle_req_i)
          next_mode = (sleep_cfg == SLP_IDLE) ? PDC_IDLE : PDC_SLEEP;
      PDC_IDLE,
      PDC_SLEEP:
        if (!idle_req_i)
          next_mode = PDC_RUN;
      PDC_PDOWN:
        next_mode = PDC_PDOWN;
      default:
        next_mode = PDC_RUN;
    endcase
  end

  // only a reset (srst_i or the external reset pin) leaves power-down
  always_ff @(posedge clk_i)
  begin
    if (ext_rst)
      mode <= PDC_RUN;
    else
      mode <= next_mode;
  end

  assign stopped = (mode == PDC_SLEEP) || (mode == PDC_PDOWN);

  // freeze of the live pins while clocks are stopped
  pdc_hold u_hold (
    .clk_i    (clk_i),
    .srst_i   (srst_i),
    .freeze_i (stopped),
    .d_i      (live_pins_i),
    .q_o      (held)
  );

  // pin multiplexer per mode
  always_comb
  begin
    next_pins = live_pins_i;
    case (mode)
      PDC_IDLE:
      begin
        next_pins.ale = 1'b0;
        next_pins.rd_n = 1'b1;
        next_pins.wr_n = 1'b1;
        if (|address_window_active_bit)
        begin
          next_pins.p0_oe[7:0] = 8'h00;
          next_pins.p0_val[10:8] = last_addr_i.hi;
          next_pins.p0_oe[10:8] = mux8 ? 3'h7 : 3'h0;
          next_pins.p1_val = demux ? last_addr_i.lo : p1_latch_i;
          next_pins.p1_oe = 16'hFFFF;
        end
      end
      PDC_SLEEP,
      PDC_PDOWN:
      begin
        next_pins = held;
        next_pins.system_clock_output = 1'b1;
        next_pins.programmable_frequency_output = held.programmable_frequency_output;
        if (mode == PDC_PDOWN && power_down_pin_counter_control[0])
        begin
          next_pins.p0_oe = 16'h0000;
          next_pins.p1_oe = 16'h0000;
        end
      end
      default:
        next_pins = live_pins_i;
    endcase
    // released bus plus input direction turns bus drivers off
    if (!(|address_window_active_bit))
    begin
      next_pins.p0_oe = next_pins.p0_oe & port_dir_out;
      next_pins.p0_val = (mode == PDC_RUN) ? p0_latch_i : next_pins.p0_val;
    end
  end

  // pin outputs registered
  always_ff @(posedge clk_i)
  begin
    if (ext_rst)
    begin
      pins_o <= '0;
      pins_o.rd_n <= 1'b1;
      pins_o.wr_n <= 1'b1;
    end
    else
      pins_o <= next_pins;
  end

  // clock gating and retention
  always_comb
  begin
    core_clk_en_o = (mode == PDC_RUN);
    wdt_run_o = (mode == PDC_RUN) || (mode == PDC_IDLE);
    tod_clk_en_o = (mode != PDC_PDOWN) ||
                   !power_down_pin_counter_control[1];
    tod_osc_en_o = tod_clk_en_o;
    ram_retain_o = 1'b1;
    sys_reset_o = ext_rst;
    bus_pins_en_o = |address_window_active_bit;
    mode_o = mode;
  end

  // register read data
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      avs_readdata_o <= 32'h0000_0000;
    else if (bus_rd)
      case (avs_address_i)
        OFS_CTRL:   avs_readdata_o <= {26'h0, power_down_pin_counter_control,
                                       2'h0, sleep_cfg};
        OFS_STATUS: avs_readdata_o <= {26'h0, mode, 2'h0, flag_pdr, flag_pon};
        OFS_BUS:    avs_readdata_o <= {port_dir_out, 6'h00, demux, mux8,
                                       address_window_active_bit};
        OFS_CMD:    avs_readdata_o <= {cmd_hi, 16'h0000};
        default:    avs_readdata_o <= 32'h0000_0000;
      endcase
  end

  // assertions
  pd_sticky_a: assert property (@(posedge clk_i) disable iff (ext_rst)
    mode == PDC_PDOWN |=> mode == PDC_PDOWN)
    else $error("left power-down without reset");
  pd_entry_a: assert property (@(posedge clk_i) disable iff (ext_rst)
    (mode == PDC_RUN && next_mode == PDC_PDOWN) |-> instr_done_i && pd_armed)
    else $error("power-down entered without completed instruction");
  wdt_halt_a: assert property (@(posedge clk_i) disable iff (ext_rst)
    mode == PDC_PDOWN |-> !wdt_run_o && !core_clk_en_o)
    else $error("watchdog or core clock running in power-down");
  tod_osc_a: assert property (@(posedge clk_i) disable iff (ext_rst)
    tod_clk_en_o |-> tod_osc_en_o)
    else $error("counter running without oscillator");
  idle_strb_a: assert property (@(posedge clk_i) disable iff (ext_rst)
    $past(mode) == PDC_IDLE && mode == PDC_IDLE |->
      !pins_o.ale && pins_o.rd_n && pins_o.wr_n)
    else $error("bus strobes active in idle");
  clk_high_a: assert property (@(posedge clk_i) disable iff (ext_rst)
    stopped && $past(stopped) |-> pins_o.system_clock_output)
    else $error("clock output not high while stopped");
  arm_nmi_a: assert property (@(posedge clk_i) disable iff (ext_rst)
    $rose(pd_armed) |-> $past(!nmi_n_s))
    else $error("armed with nmi high");
  pins_off_a: assert property (@(posedge clk_i) disable iff (ext_rst)
    mode == PDC_PDOWN && $past(mode) == PDC_PDOWN &&
      power_down_pin_counter_control[0] |-> pins_o.p1_oe == 16'h0000)
    else $error("pin drivers on in power-down");
  flag_pdr_a: assert property (@(posedge clk_i) disable iff (srst_i || por_i)
    mode == PDC_PDOWN && !rst_n_s |=> flag_pdr)
    else $error("restart flag not set");
endmodule

//--- pdc_supply_model.sv
// power-failure supervisor and reset circuit facing the controller
// assumes the bench clock; fail_i and rst_req_i come from the bench
`timescale 1ns/100ps
module pdc_supply_model
  import pdc_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       fail_i,
  input  wire logic       rst_req_i,
  input  wire logic [1:0] mode_i,
  output logic            nmi_n_o,
  output logic            hw_reset_n_o
);
  logic [2:0] rst_cnt;

  initial nmi_n_o = 1'b1;
  initial rst_cnt = 3'h0;

  // nmi low while fail_i is high; once fail_i drops, released when power-down is in or while the reset pin is held low
  always @(posedge clk_i)
  begin
    if (fail_i)
      nmi_n_o <= 1'b0;
    else if (mode_i == PDC_PDOWN || rst_cnt != 3'h0)
      nmi_n_o <= 1'b1;
  end

  // reset pin held low four cycles, long enough for the synchroniser
  always @(posedge clk_i)
  begin
    if (rst_req_i)
      rst_cnt <= 3'h4;
    else if (rst_cnt != 3'h0)
      rst_cnt <= rst_cnt - 3'h1;
  end
  assign hw_reset_n_o = (rst_cnt == 3'h0);
endmodule

//--- power_down_mode_control_test.sv
// self-checking bench for the power-down controller
// assumes pdc_top, pdc_pkg and the supply model are compiled first
`timescale 1ns/100ps
module power_down_mode_control_test;
  import pdc_pkg::*;
  logic        clk_i = 0, srst_i = 1, por_i = 1;
  logic        rd = 0, wr = 0, done = 0, idle = 0, fail = 0, rreq = 0;
  logic [3:0]  adr = 4'h0;
  logic [31:0] wd = 32'h0, rdv, rdata;
  pdc_pins_t   live = '0, pins, old;
  logic        nmi_n, hrn, wreq, cce, wdt, tce, toe, ram, srs, bpe;
  logic [1:0]  mode;
  logic [15:0] dir;
  int          miscompares = 0, check_count = 0, k;
  // last bus address seen by the controller, fields set apart
  localparam pdc_addr_t LAST_ADDR = '{lo: 16'hA5C3, hi: 3'h2};

  always #2 clk_i = ~clk_i;

  pdc_supply_model sup (.clk_i(clk_i), .fail_i(fail), .rst_req_i(rreq),
    .mode_i(mode), .nmi_n_o(nmi_n), .hw_reset_n_o(hrn));

  pdc_top dut (.clk_i(clk_i), .srst_i(srst_i), .por_i(por_i),
    .hw_reset_n_i(hrn), .nmi_n_i(nmi_n), .avs_address_i(adr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
    .avs_byteenable_i(4'hF), .avs_readdata_o(rdata),
    .avs_waitrequest_o(wreq), .instr_done_i(done), .idle_req_i(idle),
    .live_pins_i(live), .last_addr_i(LAST_ADDR),
    .p0_latch_i(16'hA55A), .p1_latch_i(16'h3CC3), .pins_o(pins),
    .core_clk_en_o(cce), .wdt_run_o(wdt), .tod_clk_en_o(tce),
    .tod_osc_en_o(toe), .ram_retain_o(ram), .sys_reset_o(srs),
    .bus_pins_en_o(bpe), .mode_o(mode));

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(string n, logic [31:0] e, logic [31:0] s);
    check_count++;
    if (s !== e)
    begin
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      miscompares++;
    end
  endtask

  // one avalon transfer; data taken at the edge waitrequest is low
  task automatic bus(logic w, logic [3:0] a, logic [31:0] d);
    int n;
    @(posedge clk_i);
    adr <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wreq !== 1'b0 && n < 50);
    if (n >= 50)
    begin
      miscompares++;
      wrap_up();
    end
    if (!w)
      rdv = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask

  // command word, then completion pulse; mode must wait for it
  task automatic enter(logic [31:0] cmd, logic nmi_low, logic [1:0] e);
    fail <= nmi_low;
    repeat (4) @(posedge clk_i);
    bus(1'b1, OFS_CMD, cmd);
    repeat (3) @(posedge clk_i);
    #1 chk("mode before done", 32'(PDC_RUN), 32'(mode));
    @(posedge clk_i);
    done <= 1'b1;
    @(posedge clk_i);
    done <= 1'b0;
    @(posedge clk_i);
    #1 chk("mode after done", 32'(e), 32'(mode));
  endtask

  task automatic hw_exit;
    @(posedge clk_i);
    rreq <= 1'b1;
    fail <= 1'b0;
    @(posedge clk_i);
    rreq <= 1'b0;
    repeat (3) @(posedge clk_i);
    #1 chk("reset during exit", 32'h1, 32'(srs));
    repeat (7) @(posedge clk_i);
  endtask

  // hang guard far above the bench's run time
  initial
  begin
    #200000;
    miscompares++;
    wrap_up();
  end

  initial
  begin
    void'($urandom(15));
    live = pdc_pins_t'(69'({$urandom, $urandom, $urandom}));
    repeat (3) @(posedge clk_i);
    srst_i <= 1'b0;
    // power-on indication outlasts the reset so the flag can be set
    @(posedge clk_i);
    por_i <= 1'b0;
    bus(1'b0, OFS_STATUS, 32'h0);
    chk("power-on flag", 32'h1, 32'(rdv[FLAG_PON]));
    bus(1'b0, OFS_CTRL, 32'h0);
    chk("power_down_pin_counter_control reset", 32'(POWER_DOWN_PIN_COUNTER_CONTROL_RESET), 32'(rdv[5:4]));
    $display("test reset values done");
    // idle with an external bus: one window, mux8 and demux set
    bus(1'b1, OFS_BUS, 32'h0000_0301);
    @(posedge clk_i);
    idle <= 1'b1;
    repeat (4) @(posedge clk_i);
    #1 chk("idle mode", 32'(PDC_IDLE), 32'(mode));
    chk("idle strobes", 32'h3, 32'({pins.ale, pins.rd_n, pins.wr_n}));
    chk("bus pins on", 32'h1, 32'(bpe));
    chk("p1 address", 32'(LAST_ADDR.lo), 32'(pins.p1_val));
    chk("p0 high addr", 32'(LAST_ADDR.hi), 32'(pins.p0_val[10:8]));
    chk("p0 enables", 32'h700, 32'(pins.p0_oe[10:0]));
    idle <= 1'b0;
    repeat (4) @(posedge clk_i);
    bus(1'b1, OFS_BUS, 32'h0);
    #1 chk("bus pins off", 32'h0, 32'(bpe));
    $display("test idle done");
    // sleep: pins frozen, clock output high
    bus(1'b1, OFS_CTRL, 32'h1);
    old = live;
    @(posedge clk_i);
    idle <= 1'b1;
    repeat (3) @(posedge clk_i);
    live <= pdc_pins_t'(69'({$urandom, $urandom, $urandom}));
    repeat (3) @(posedge clk_i);
    #1 chk("sleep mode", 32'(PDC_SLEEP), 32'(mode));
    chk("sleep system_clock_output", 32'h1, 32'(pins.system_clock_output));
    chk("sleep programmable_frequency_output", 32'(old.programmable_frequency_output), 32'(pins.programmable_frequency_output));
    chk("sleep p1", 32'(old.p1_val), 32'(pins.p1_val));
    idle <= 1'b0;
    repeat (4) @(posedge clk_i);
    bus(1'b1, OFS_CTRL, 32'h0);
    $display("test sleep done");
    enter({PD_OP_HI, PD_OP_LO ^ 16'h0001}, 1'b1, PDC_RUN);
    hw_exit();
    enter({PD_OP_HI, PD_OP_LO}, 1'b0, PDC_RUN);
    $display("test refused entries done");
    for (k = 0; k < 4; k++)
    begin
      bus(1'b1, OFS_CTRL, 32'(k) << POWER_DOWN_PIN_COUNTER_CONTROL_LSB);
      // random port directions, no window active
      dir = 16'($urandom);
      bus(1'b1, OFS_BUS, {dir, 16'h0000});
      old = live;
      enter({PD_OP_HI, PD_OP_LO}, 1'b1, PDC_PDOWN);
      chk("core clock", 32'h0, 32'(cce));
      chk("ram retain", 32'h1, 32'(ram));
      chk("watchdog", 32'h0, 32'(wdt));
      chk("tod clock", 32'(k < 2), 32'(tce));
      chk("tod osc", 32'(k < 2), 32'(toe));
      live <= pdc_pins_t'(69'({$urandom, $urandom, $urandom}));
      idle <= 1'b1;
      fail <= 1'b0;
      repeat (6) @(posedge clk_i);
      #1 chk("still down", 32'(PDC_PDOWN), 32'(mode));
      chk("wdt held", 32'h0, 32'(wdt));
      chk("system_clock_output", 32'h1, 32'(pins.system_clock_output));
      chk("programmable_frequency_output", 32'(old.programmable_frequency_output), 32'(pins.programmable_frequency_output));
      chk("p1 value", 32'(old.p1_val), 32'(pins.p1_val));
      chk("p0 enable", k[0] ? 32'h0 : 32'(old.p0_oe & dir), 32'(pins.p0_oe));
      idle <= 1'b0;
      hw_exit();
      chk("mode after exit", 32'(PDC_RUN), 32'(mode));
      bus(1'b0, OFS_CTRL, 32'h0);
      chk("power_down_pin_counter_control after exit", 32'(POWER_DOWN_PIN_COUNTER_CONTROL_RESET), 32'(rdv[5:4]));
      bus(1'b0, OFS_STATUS, 32'h0);
      chk("restart flag", 32'h1, 32'(rdv[FLAG_PDR]));
      bus(1'b1, OFS_STATUS, 32'h2);
      $display("test power-down code %0d done", k);
    end
    wrap_up();
  end
endmodule
